/* File: bench/pxbr_cards.sv */
// pxbr_cards: two add-in cards as seen through the bridge's setup write port
// assumes cfg_* are registers of the bridge, sampled on the rising clock edge
`timescale 1ns/10ps
module pxbr_cards
  import pxbr_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        resetn,
  // configuration writes from the bridge
  input  wire logic        cfg_wr,
  input  wire logic        cfg_slot,
  input  wire logic [7:0]  cfg_off,
  input  wire logic [15:0] cfg_data,
  // configuration space contents of each card, and a count of all writes
  output logic [1:0][15:0] cmd_seen,
  output logic [1:0][7:0]  cls_seen,
  output logic [1:0][7:0]  lat_seen,
  output logic      [7:0]  n_wr
);
  // cards take every write at once and never touch their base registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_seen <= '0;
      cls_seen <= '0;
      lat_seen <= '0;
      n_wr     <= 8'h00;
    end else if (cfg_wr) begin
      n_wr <= n_wr + 8'h01;
      if (cfg_off == CFG_CMD_OFF) cmd_seen[cfg_slot] <= cfg_data;
      if (cfg_off == CFG_CLS_OFF) cls_seen[cfg_slot] <= cfg_data[7:0];
      if (cfg_off == CFG_LAT_OFF) lat_seen[cfg_slot] <= cfg_data[7:0];
    end
  end
endmodule

/* File: bench/test_pxbr_top.sv */
// test_pxbr_top: register-level tests of setup, bus speed, pio space and dma map
// assumes pxbr_cards on the setup port and two window mapping registers
`timescale 1ns/10ps
module test_pxbr_top
  import pxbr_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, pio_addr_i = 32'h0, wb_dat_o, pio_addr;
  logic [1:0] slot_present = 2'h0, slot_pcix = 2'h0, slot_cap0 = 2'h0, slot_cap1 = 2'h0;
  logic lock_n = 1'b1, sbo_n = 1'b1, sdone = 1'b0, dma_req = 1'b0, dma_dac = 1'b0;
  logic pio_req = 1'b0;
  logic [63:0] dma_addr = 64'h0;
  logic [1:0] bus_speed, slot_enable, cfg_ready;
  logic wb_ack_o, bus_pcix_mode, cfg_wr, cfg_slot, dma_ack, dma_err, bus_err, pio_start;
  logic pio_dac;
  logic [7:0] cfg_off, n_wr, n0;
  logic [15:0] cfg_data;
  logic [PHYS_W-1:0] dma_phys;
  logic [1:0][15:0] cmd_seen;
  logic [1:0][7:0] cls_seen, lat_seen;
  int n_errors = 0, checks_done = 0;
  // population table: present, pci-x, caps, speed, pci-x mode, slot 1 min grant
  logic [1:0] tp [6] = '{2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
  logic [1:0] tx [6] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h0, 2'h0};
  logic [1:0] t0 [6] = '{2'h3, 2'h3, 2'h1, 2'h3, 2'h1, 2'h0};
  logic [1:0] t1 [6] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h0, 2'h3};
  logic [1:0] ts [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0, 2'h1};
  logic       tm [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [7:0] tg [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h10};
  int lus [4] = '{33, 66, 100, 133};
  int mlt [4] = '{8, 16, 24, 32};

  pxbr_top #(.MAP_N(2)) i_dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .slot_present, .slot_pcix, .slot_cap0,
    .slot_cap1, .bus_speed, .bus_pcix_mode, .slot_enable, .lock_n, .sbo_n, .sdone, .cfg_wr,
    .cfg_slot, .cfg_off, .cfg_data, .cfg_ready, .dma_req, .dma_dac, .dma_addr, .dma_ack,
    .dma_err, .dma_phys, .bus_err, .pio_req, .pio_addr_i, .pio_start, .pio_addr, .pio_dac);
  pxbr_cards i_cards (.clk, .resetn, .cfg_wr, .cfg_slot, .cfg_off, .cfg_data, .cmd_seen,
    .cls_seen, .lat_seen, .n_wr);

  initial begin
    forever #2 clk = ~clk;
  end

  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, q & m, e);
  endtask

  task automatic boot(input logic [1:0] p, input logic [1:0] x, input logic [1:0] c0,
                      input logic [1:0] c1);
    @(posedge clk);
    resetn       <= 1'b0;
    slot_present <= p;
    slot_pcix    <= x;
    slot_cap0    <= c0;
    slot_cap1    <= c1;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic setup(input logic s, input logic [7:0] mg);
    wr(OFF_CFG, {16'h0, mg, 7'h0, s});
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic dma(input logic dac, input logic [63:0] a, input logic e,
                     input logic [PHYS_W-1:0] p);
    @(posedge clk);
    dma_req  <= 1'b1;
    dma_dac  <= dac;
    dma_addr <= a;
    @(posedge clk);
    dma_req <= 1'b0;
    #1;
    check("dma ack", dma_ack, 1'b1);
    check("dma err", dma_err, e);
    check("bus err", bus_err, e);
    check("dma phys", dma_phys, p);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    int lat;
    for (int i = 0; i < 6; i++) begin
      boot(tp[i], tx[i], t0[i], t1[i]);
      check("speed", bus_speed, ts[i]);
      check("pcix mode", bus_pcix_mode, tm[i]);
      check("slot enable", slot_enable, tp[i]);
      rdc("speed reg", OFF_SPEED, 32'h1f, {27'h0, tp[i], tm[i], ts[i]});
      for (int s = 0; s < 2; s++) begin
        lat = (s == 0) ? lus[ts[i]] : tg[i] * mlt[ts[i]];
        n0 = n_wr;
        setup(s[0], (s == 0) ? 8'h00 : tg[i]);
        if (tp[i][s]) begin
          check("cmd", cmd_seen[s], 16'h0007);
          check("cls", cls_seen[s], 8'h20);
          check("lat", lat_seen[s], (lat > 255) ? 255 : lat);
          check("ready", cfg_ready[s], 1'b1);
          n0 = n_wr;
          setup(s[0], 8'h00);
        end
        rdc("refused", OFF_CFG, 32'h8, 32'h8);
        check("cfg writes", n_wr, n0);
      end
    end
    wr(OFF_ALLOC, {19'h0, 5'h0c, 8'h00});
    rdc("alloc ok", OFF_ALLOC, 32'h3, 32'h1);
    rdc("mem base", OFF_ABASE, 32'hffffffff, 32'h0000_1000);
    wr(OFF_ALLOC, {19'h0, 5'h10, 8'h00});
    rdc("mem base 2", OFF_ABASE, 32'hffffffff, 32'h0001_0000);
    wr(OFF_ALLOC, {19'h0, 5'h1a, 8'h00});
    rdc("alloc fail", OFF_ALLOC, 32'h3, 32'h2);
    wr(OFF_ALLOC, {19'h0, 5'h04, 8'h01});
    rdc("io base", OFF_ABASE, 32'hffffffff, 32'h0000_1000);
    rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
    lock_n <= 1'b0;
    sbo_n  <= 1'b0;
    sdone  <= 1'b1;
    wr(OFF_MAP, 32'h0123_4567);
    rdc("map 0", OFF_MAP, 32'hff03, 32'h0001);
    wr(OFF_MAP, 32'h0fed_cba9);
    rdc("map 1", OFF_MAP, 32'hff03, 32'h0101);
    wr(OFF_MAP, 32'h0111_1111);
    rdc("map full", OFF_MAP, 32'h3, 32'h2);
    dma(1'b0, 64'h0040_1234, 1'b0, {28'hfed_cba9, 22'h00_1234});
    dma(1'b0, 64'h0000_0abc, 1'b0, {28'h123_4567, 22'h00_0abc});
    dma(1'b0, 64'h0080_0000, 1'b1, '0);
    dma(1'b0, 64'h1_0000_0000, 1'b1, '0);
    dma(1'b1, 64'h3_ffff_ffff_fff8, 1'b0, 50'h3_ffff_ffff_fff8);
    dma(1'b1, 64'h4_0000_0000_0000, 1'b1, '0);
    wr(OFF_UNMAP, 32'h0);
    dma(1'b0, 64'h0000_0abc, 1'b1, '0);
    wr(OFF_MAP, 32'h0111_1111);
    rdc("map again", OFF_MAP, 32'hff03, 32'h0001);
    dma(1'b0, 64'h0000_0abc, 1'b0, {28'h111_1111, 22'h00_0abc});
    rdc("err sticky", OFF_ERR, 32'h1, 32'h1);
    wr(OFF_ERR, 32'h1);
    rdc("err clear", OFF_ERR, 32'h1, 32'h0);
    @(posedge clk);
    pio_req    <= 1'b1;
    pio_addr_i <= 32'h0000_2340;
    @(posedge clk);
    pio_req <= 1'b0;
    #1;
    check("pio start", pio_start, 1'b1);
    check("pio addr", pio_addr, 32'h0000_2340);
    check("pio dac", pio_dac, 1'b0);
    wrap_up();
  end
endmodule

/* File: core/pxbr_pkg.sv */
// pxbr_pkg: constants and types of the pci-x host bridge setup/dma map block
// assumes a 32-bit classic wishbone register bus and a 250 MHz system clock
package pxbr_pkg;
  // -------------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------------
  localparam logic [7:0]  OFF_CFG       = 8'h00;
  localparam logic [7:0]  OFF_SPEED     = 8'h04;
  localparam logic [7:0]  OFF_ALLOC     = 8'h08;
  localparam logic [7:0]  OFF_ABASE     = 8'h0c;
  localparam logic [7:0]  OFF_MAP       = 8'h10;
  localparam logic [7:0]  OFF_UNMAP     = 8'h14;
  localparam logic [7:0]  OFF_ERR       = 8'h18;
  // -------------------------------------------------------------------
  // write field positions
  // -------------------------------------------------------------------
  localparam int          F_SLOT        = 0;
  localparam int          F_MINGNT      = 8;
  localparam int          F_IOSEL       = 0;
  localparam int          F_LGSZ        = 8;
  localparam int          F_ERRCLR      = 0;
  // -------------------------------------------------------------------
  // configuration space setup
  // -------------------------------------------------------------------
  localparam logic [7:0]  CFG_CMD_OFF   = 8'h04;
  localparam logic [7:0]  CFG_CLS_OFF   = 8'h0c;
  localparam logic [7:0]  CFG_LAT_OFF   = 8'h0d;
  localparam logic [15:0] CMD_ENABLE    = 16'h0007;
  localparam logic [15:0] CLS_VALUE     = 16'h0020;
  localparam int          LAT_US        = 1;
  localparam int          MHZ_133       = 133;
  localparam int          MHZ_100       = 100;
  localparam int          MHZ_66        = 66;
  localparam int          MHZ_33        = 33;
  localparam logic [7:0]  LAT_US_133    = 8'(MHZ_133 * LAT_US);
  localparam logic [7:0]  LAT_US_100    = 8'(MHZ_100 * LAT_US);
  localparam logic [7:0]  LAT_US_66     = 8'(MHZ_66 * LAT_US);
  localparam logic [7:0]  LAT_US_33     = 8'(MHZ_33 * LAT_US);
  localparam logic [7:0]  MULT_133      = 8'h20;
  localparam logic [7:0]  MULT_100      = 8'h18;
  localparam logic [7:0]  MULT_66       = 8'h10;
  localparam logic [7:0]  MULT_33       = 8'h08;
  // -------------------------------------------------------------------
  // pio space and dma translation
  // -------------------------------------------------------------------
  localparam logic [32:0] PIO_MEM_START = 33'h0_0000_1000;
  localparam logic [32:0] PIO_MEM_LIMIT = 33'h0_0400_0000;
  localparam logic [32:0] PIO_IO_START  = 33'h0_0000_1000;
  localparam logic [32:0] PIO_IO_LIMIT  = 33'h0_0001_0000;
  localparam logic [4:0]  LG_MIN        = 5'h04;
  localparam int          PHYS_W        = 50;
  localparam int          PG_SH         = 22;
  localparam int          PG_W          = PHYS_W - PG_SH;

  typedef enum logic [1:0] {SPD_33, SPD_66, SPD_100, SPD_133} pxbr_speed_t;
  typedef enum logic [1:0] {CS_IDLE, CS_CMD, CS_CLS, CS_LAT} pxbr_cfg_t;
endpackage

/* File: core/pxbr_top.sv */
// pxbr_top: pci-x host bridge - device setup, bus speed, pio space, dma map
// assumes synchronous slot/dma/pio inputs and a classic wishbone master
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
module pxbr_top
  import pxbr_pkg::*;
#(
  parameter int MAP_N = 8
) (
  // system
  input  wire logic        clk,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // slot population
  input  wire logic [1:0]  slot_present,
  input  wire logic [1:0]  slot_pcix,
  input  wire logic [1:0]  slot_cap0,
  input  wire logic [1:0]  slot_cap1,
  output logic      [1:0]  bus_speed,
  output logic             bus_pcix_mode,
  output logic      [1:0]  slot_enable,
  // bus sideband, ignored
  input  wire logic        lock_n,
  input  wire logic        sbo_n,
  input  wire logic        sdone,
  // configuration write port
  output logic             cfg_wr,
  output logic             cfg_slot,
  output logic      [7:0]  cfg_off,
  output logic      [15:0] cfg_data,
  output logic      [1:0]  cfg_ready,
  // bus-master dma address
  input  wire logic        dma_req,
  input  wire logic        dma_dac,
  input  wire logic [63:0] dma_addr,
  output logic             dma_ack,
  output logic             dma_err,
  output logic [PHYS_W-1:0] dma_phys,
  output logic             bus_err,
  // pio master
  input  wire logic        pio_req,
  input  wire logic [31:0] pio_addr_i,
  output logic             pio_start,
  output logic      [31:0] pio_addr,
  output logic             pio_dac
);
  localparam int IW = $clog2(MAP_N);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [1:0] min2(input logic [1:0] a, input logic [1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] lat_value(input logic [7:0] mg, input logic [1:0] s);
    logic [15:0] p;
    logic [7:0]  m;
    logic [7:0]  us;
    unique case (s)
      SPD_133: begin
        m  = MULT_133;
        us = LAT_US_133;
      end
      SPD_100: begin
        m  = MULT_100;
        us = LAT_US_100;
      end
      SPD_66: begin
        m  = MULT_66;
        us = LAT_US_66;
      end
      SPD_33: begin
        m  = MULT_33;
        us = LAT_US_33;
      end
    endcase
    p = 16'(mg) * 16'(m);
    if (mg == 8'h00) return us;
    else if (|p[15:8]) return 8'hff;
    else return p[7:0];
  endfunction

  function automatic logic [32:0] align_up(input logic [32:0] p, input logic [32:0] sz);
    return (p + sz - 33'h1) & ~(sz - 33'h1);
  endfunction

  // ------------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------------
  logic [31:0] rdata_w;
  wire  [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire  [31:0] wd    = wb_dat_i & wmask;
  wire         wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire         wr_cfg   = wr && (wb_adr_i == OFF_CFG);
  wire         wr_alloc = wr && (wb_adr_i == OFF_ALLOC);
  wire         wr_map   = wr && (wb_adr_i == OFF_MAP);
  wire         wr_unmap = wr && (wb_adr_i == OFF_UNMAP);
  wire         wr_err   = wr && (wb_adr_i == OFF_ERR);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= (wb_hit && !wb_we_i) ? rdata_w : 32'h0;
    end
  end

  chk_wb_ack_pulse: assert property (
    @(posedge clk) disable iff (!resetn) wb_hit |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle answer");

  // ------------------------------------------------------------------
  // bus speed from installed cards
  // ------------------------------------------------------------------
  wire [1:0] ecap0     = slot_pcix[0] ? slot_cap0 : min2(slot_cap0, SPD_66);
  wire [1:0] ecap1     = slot_pcix[1] ? slot_cap1 : min2(slot_cap1, SPD_66);
  wire       both_pcix = &slot_pcix;
  wire [1:0] spd_two   = min2(min2(ecap0, ecap1), both_pcix ? SPD_100 : SPD_66);
  wire [1:0] spd_next  = (&slot_present) ? spd_two :
                         slot_present[0] ? ecap0 :
                         slot_present[1] ? ecap1 : SPD_33;
  wire       pcix_next = (&slot_present) ? both_pcix : |(slot_present & slot_pcix);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_speed     <= SPD_33;
      bus_pcix_mode <= 1'b0;
      slot_enable   <= 2'h0;
    end else begin
      bus_speed     <= spd_next;
      bus_pcix_mode <= pcix_next;
      slot_enable   <= slot_present; // empty slot configured down
    end
  end

  chk_speed_lone: assert property (
    @(posedge clk) disable iff (!resetn)
    bus_speed == SPD_133 |-> bus_pcix_mode && $countones(slot_enable) == 1)
    else $error("133 MHz without a single pci-x card");

  chk_speed_slowest: assert property (
    @(posedge clk) disable iff (!resetn)
    (&slot_present) && !slot_pcix[0] |=> bus_speed <= SPD_66 && !bus_pcix_mode)
    else $error("mixed bus not downgraded");

  // ------------------------------------------------------------------
  // configuration setup sequencer, once per active slot
  // ------------------------------------------------------------------
  pxbr_cfg_t  cs_reg;
  logic [7:0] mg_reg;
  logic [1:0] spd_at_reg;
  logic       cfg_refused_reg;
  wire        go_slot = wd[F_SLOT];
  wire        cfg_go  = wr_cfg && cs_reg == CS_IDLE && !cfg_ready[go_slot]
                        && slot_enable[go_slot];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_reg          <= CS_IDLE;
      mg_reg          <= 8'h00;
      spd_at_reg      <= 2'h0;
      cfg_refused_reg <= 1'b0;
      cfg_ready       <= 2'h0;
      cfg_wr          <= 1'b0;
      cfg_slot        <= 1'b0;
      cfg_off         <= 8'h00;
      cfg_data        <= 16'h0;
    end else begin
      if (wr_cfg) cfg_refused_reg <= !cfg_go;
      unique case (cs_reg)
        CS_IDLE: if (cfg_go) begin
          cs_reg     <= CS_CMD;
          mg_reg     <= wd[F_MINGNT +: 8];
          spd_at_reg <= bus_speed;
          cfg_slot   <= go_slot;
          cfg_wr     <= 1'b1;
          cfg_off    <= CFG_CMD_OFF;
          cfg_data   <= CMD_ENABLE;
        end
        CS_CMD: begin
          cs_reg   <= CS_CLS;
          cfg_off  <= CFG_CLS_OFF;
          cfg_data <= CLS_VALUE;
        end
        CS_CLS: begin
          cs_reg   <= CS_LAT;
          cfg_off  <= CFG_LAT_OFF;
          cfg_data <= {8'h00, lat_value(mg_reg, spd_at_reg)};
        end
        CS_LAT: begin
          cs_reg              <= CS_IDLE;
          cfg_wr              <= 1'b0;
          cfg_ready[cfg_slot] <= 1'b1;
        end
      endcase
    end
  end

  chk_cmd_value: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_wr && cfg_off == CFG_CMD_OFF |-> cfg_data == 16'h0007)
    else $error("command register setup value wrong");

  chk_cls_value: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_wr && cfg_off == CFG_CLS_OFF |-> cfg_data == 16'h0020)
    else $error("cache line size setup value wrong");

  chk_lat_zero: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_wr && cfg_off == CFG_LAT_OFF && mg_reg == 8'h00 && spd_at_reg == SPD_133
    |-> cfg_data == 16'h0085)
    else $error("zero min grant latency not one microsecond");

  chk_lat_mult: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_wr && cfg_off == CFG_LAT_OFF && mg_reg == 8'h03 && spd_at_reg == SPD_100
    |-> cfg_data == 16'h0048)
    else $error("latency not min grant times speed factor");

  chk_cfg_sequence: assert property (
    @(posedge clk) disable iff (!resetn)
    cfg_go |=> (cfg_wr && cfg_off == CFG_CMD_OFF) ##1 (cfg_wr && cfg_off == CFG_CLS_OFF)
    ##1 (cfg_wr && cfg_off == CFG_LAT_OFF) ##1 (!cfg_wr && cfg_ready[cfg_slot]))
    else $error("setup sequence broken");

  // ------------------------------------------------------------------
  // pio space allocator for base registers
  // ------------------------------------------------------------------
  logic [32:0] mem_ptr_reg;
  logic [32:0] io_ptr_reg;
  logic [31:0] abase_reg;
  logic        alloc_ok_reg;
  logic        alloc_fail_reg;
  wire         io_sel  = wd[F_IOSEL];
  wire  [4:0]  lg      = wd[F_LGSZ +: 5];
  wire  [4:0]  lg_c    = (lg < LG_MIN) ? LG_MIN : lg;
  wire  [32:0] asz     = 33'h1 << lg_c;
  wire  [32:0] abase_w = align_up(io_sel ? io_ptr_reg : mem_ptr_reg, asz);
  wire  [32:0] aend_w  = abase_w + asz;
  wire         afit    = aend_w <= (io_sel ? PIO_IO_LIMIT : PIO_MEM_LIMIT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ptr_reg    <= PIO_MEM_START;
      io_ptr_reg     <= PIO_IO_START;
      abase_reg      <= 32'h0;
      alloc_ok_reg   <= 1'b0;
      alloc_fail_reg <= 1'b0;
    end else if (wr_alloc) begin
      alloc_ok_reg   <= afit;
      alloc_fail_reg <= !afit;
      if (afit) begin
        abase_reg <= abase_w[31:0];
        if (io_sel) io_ptr_reg <= aend_w;
        else mem_ptr_reg <= aend_w;
      end
    end
  end

  chk_pio_limit: assert property (
    @(posedge clk) disable iff (!resetn)
    mem_ptr_reg <= 33'h0_0400_0000 && io_ptr_reg <= PIO_IO_LIMIT)
    else $error("pio space allocated past its limit");

  // ------------------------------------------------------------------
  // 32-bit window mapping registers
  // ------------------------------------------------------------------
  logic [MAP_N-1:0] map_vld;
  logic [PG_W-1:0]  map_pg [MAP_N];
  logic [IW-1:0]    map_idx_reg;
  logic             map_ok_reg;
  logic             map_fail_reg;
  logic [IW-1:0]    free_idx;
  logic             free_any;
  wire  [IW-1:0]    unmap_idx = wd[IW-1:0];

  always_comb begin
    free_idx = '0;
    free_any = 1'b0;
    for (int i = MAP_N - 1; i >= 0; i--) begin
      if (!map_vld[i]) begin
        free_idx = IW'(i);
        free_any = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      map_vld      <= '0;
      map_idx_reg  <= '0;
      map_ok_reg   <= 1'b0;
      map_fail_reg <= 1'b0;
    end else if (wr_map) begin
      map_ok_reg   <= free_any;
      map_fail_reg <= !free_any;
      if (free_any) begin
        map_vld[free_idx] <= 1'b1;
        map_idx_reg       <= free_idx;
      end
    end else if (wr_unmap && int'(unmap_idx) < MAP_N) begin
      map_vld[unmap_idx] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_map && free_any) map_pg[free_idx] <= wd[PG_W-1:0];
  end

  chk_map_refuse: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_map && !free_any |=> map_fail_reg && !map_ok_reg && map_vld == $past(map_vld))
    else $error("refused map changed state or hid failure");

  // ------------------------------------------------------------------
  // dma address translation, one cycle
  // ------------------------------------------------------------------
  wire [31-PG_SH:0] win_full = dma_addr[31:PG_SH];
  wire [IW-1:0]     win      = win_full[IW-1:0];
  wire              win_hit  = dma_addr[63:32] == 32'h0 && int'(win_full) < MAP_N
                               && map_vld[win];
  wire              dac_hit  = dma_addr[63:PHYS_W] == '0;
  wire              dma_ok   = dma_dac ? dac_hit : win_hit;
  wire [PHYS_W-1:0] phys_w   = dma_dac ? dma_addr[PHYS_W-1:0]
                               : {map_pg[win], dma_addr[PG_SH-1:0]};
  logic             err_sticky_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dma_ack        <= 1'b0;
      dma_err        <= 1'b0;
      dma_phys       <= '0;
      bus_err        <= 1'b0;
      err_sticky_reg <= 1'b0;
    end else begin
      dma_ack        <= dma_req;
      dma_err        <= dma_req && !dma_ok;
      bus_err        <= dma_req && !dma_ok;
      err_sticky_reg <= (dma_req && !dma_ok) || (err_sticky_reg && !(wr_err && wd[F_ERRCLR]));
      if (dma_req) dma_phys <= dma_ok ? phys_w : '0;
    end
  end

  chk_dac_direct: assert property (
    @(posedge clk) disable iff (!resetn)
    dma_req && dma_dac && dma_addr[63:50] == 14'h0
    |=> dma_ack && !dma_err && dma_phys == $past(dma_addr[49:0]))
    else $error("dual address not mapped directly");

  chk_bus_err: assert property (
    @(posedge clk) disable iff (!resetn)
    dma_req && dma_dac && dma_addr[63:50] != 14'h0 |=> bus_err ##1 err_sticky_reg)
    else $error("invalid physical address gave no bus error");

  // ------------------------------------------------------------------
  // pio master: 32-bit single address only; lock and snoop unused
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pio_start <= 1'b0;
      pio_addr  <= 32'h0;
      pio_dac   <= 1'b0;
    end else begin
      pio_start <= pio_req;
      pio_addr  <= pio_addr_i;
      pio_dac   <= 1'b0;
    end
  end

  chk_pio_single: assert property (
    @(posedge clk) disable iff (!resetn)
    pio_req |=> pio_start && !pio_dac && pio_addr == $past(pio_addr_i))
    else $error("pio cycle not a 32-bit single address");

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  assign rdata_w =
    (wb_adr_i == OFF_CFG)   ? {28'h0, cfg_refused_reg, cs_reg != CS_IDLE, cfg_ready} :
    (wb_adr_i == OFF_SPEED) ? {27'h0, slot_enable, bus_pcix_mode, bus_speed} :
    (wb_adr_i == OFF_ALLOC) ? {30'h0, alloc_fail_reg, alloc_ok_reg} :
    (wb_adr_i == OFF_ABASE) ? abase_reg :
    (wb_adr_i == OFF_MAP)   ? {16'h0, 8'(map_idx_reg), 6'h0, map_fail_reg, map_ok_reg} :
    (wb_adr_i == OFF_ERR)   ? {31'h0, err_sticky_reg} : 32'h0;
endmodule
